// *** mmt_pin_model.sv ***
// External pulse source driving the timer input pins
`timescale 1ns/1ps
`default_nettype none
module mmt_pin_model (
	input wire logic aclk,
	input wire logic aresetn,
	output logic [4:0] channel_input_pin,
	output logic zphase_pin,
	output logic ext_event_in
);
	logic [3:0] cnt_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) cnt_r <= 4'h0;
		else cnt_r <= cnt_r + 4'h1;
	end
	// Square wave of eight cycles on every channel input, Z-phase held low, one-cycle event pulse
	assign channel_input_pin = {5{cnt_r[2]}};
	assign zphase_pin = 1'b0;
	assign ext_event_in = (cnt_r == 4'hf);
endmodule
`default_nettype wire

// *** mmt_pkg.sv ***
// Types shared by the timer bank
package mmt_pkg;
	typedef enum logic [1:0] {
		MMT_TIMER,
		MMT_EVENT,
		MMT_ONESHOT,
		MMT_PWM
	} mmt_mode_e;
	typedef enum logic [1:0] {
		MMT_IDLE,
		MMT_HI,
		MMT_LO
	} mmt_st_e;
endpackage

// *** mmt_props.sv ***
// Bus handshake checks for the timer bank
`timescale 1ns/1ps
`default_nettype none
module mmt_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while response pending");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read ready while data pending");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data not released");
	err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
		else $error("refused read returned data");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
`default_nettype wire

// *** mmt_regs.svh ***
// Register indices, field positions, reset values and divider figures
`ifndef MMT_REGS_SVH
`define MMT_REGS_SVH
`define MMT_IDX_PCLK 10'h012
`define MMT_IDX_PDIV 10'h1cb
`define MMT_IDX_SRC0 10'h1d0
`define MMT_IDX_PWM_FUNCTION_SELECT 10'h1d4
`define MMT_IDX_POL 10'h1d5
`define MMT_IDX_OW 10'h1d8
`define MMT_IDX_RL2 10'h300
`define MMT_IDX_RUN 10'h320
`define MMT_IDX_ONE_SHOT_START_FLAGS 10'h322
`define MMT_IDX_TRG 10'h323
`define MMT_IDX_UDF 10'h324
`define MMT_IDX_CNT 10'h328
`define MMT_IDX_MODE 10'h336
`define MMT_RST_PCLK 1'b1
`define MMT_RST_BYTE 8'h00
`define MMT_RST_WORD 16'h0000
`define MMT_MSK_PO 8'h16
`define MMT_MSK_POL 8'h1f
`define MMT_MSK_RUN 8'h1f
`define MMT_MSK_ONE_SHOT_START_FLAGS 8'he0
`define MMT_MSK_PCLK 8'h01
`define MMT_MSK_PDIV 8'h02
`define MMT_BIT_PDIV 1
`define MMT_BIT_ZPH 5
`define MMT_BIT_QD 3
`define MMT_MR_OUT 2
`define MMT_MR_EDGE 3
`define MMT_MR_TRG 4
`define MMT_MR_W8 5
`define MMT_SH_PDIV 4'd2
`define MMT_SH_D8 4'd3
`define MMT_SH_D32 4'd5
`define MMT_SH_D64 4'd6
`define MMT_PWM16_END 16'hfffe
`define MMT_PWM8_END 8'hfe
`define MMT_RESP_OK 2'b00
`define MMT_RESP_ERR 2'b10
`endif

// *** mmt_top.sv ***
// Five-channel multi-mode timer bank with AXI4-Lite registers
// How it works
// - Channels 1, 2, 4 select bit: 0 16-bit PWM, 1 programmable output.
// - Select bit counts only in mode 11b with 16-bit PWM width.
// - Per-channel polarity bit inverts the output when set.
// - Waveform update enable acts only in programmable output mode.
// - New values load if enable is set at end of low phase.
// - Enable clear at that point reloads the previous values.
// - One-shot with counter zero never starts, no request, no pulse.
// - 16-bit PWM with zero stays idle, output low, no request.
// - 8-bit PWM: low byte prescales, high byte width; zero high idles.
// - One-shot with trigger bit 0 starts on go bit while running.
// - Z-phase enable reinitialises channel 3 in two-phase counting only.
// - Channel 0 trigger field used only when its trigger bit is 1.
// - Trigger field 00b takes the input pin edge chosen by mode bit.
// - Field 01b takes the external event input, 10b/11b the previous/next channel's timer request, unmasked.
// - Channels 1-4 trigger fields sit in pairs b1-b0 to b7-b6.
// - Direction bit acts only in event mode without two-phase.
// - Source fields b3-b0/b7-b4; peripheral choice picks undivided or halved.
// - Mode field: 00 timer, 01 event, 10 one-shot, 11 PWM/prog output.
// - Counter write loads both when stopped, only reload when counting.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mmt_regs.svh"
module mmt_top
	import mmt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [4:0] channel_input_pin,
	input wire logic zphase_pin,
	input wire logic ext_event_in,
	output logic [4:0] channel_output_pin,
	output logic [4:0] timer_request
);
	logic aw_have_r, w_have_r;
	logic [9:0] aw_idx_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic [7:0] pclk_r, pdiv_r, pwm_function_select_r, pol_r, ow_r, run_r, one_shot_start_flags_r, trg_r, udf_r;
	logic [7:0] src_r [3];
	logic [7:0] mode_r [5];
	logic [4:0] go_r;
	logic [7:0] dv_r;
	logic [15:0] cnt_q [5];
	logic [15:0] rld_q [5];
	logic [15:0] rl2_q [5];
	logic [4:0] irq_q;
	logic [31:0] rd_data;
	logic rd_ok, wr_ok;
	logic [9:0] ar_idx;
	logic wr_go;
	logic [3:0] base_sh;
	logic [3:0] tks;
	logic [23:0] src_all;
	logic [9:0] tsel_all;

	function automatic logic idx_ok(input logic [9:0] x);
		return x == `MMT_IDX_PCLK || x == `MMT_IDX_PDIV || x == `MMT_IDX_POL
			|| (x >= `MMT_IDX_SRC0 && x <= `MMT_IDX_SRC0 + 10'h002)
			|| x == `MMT_IDX_PWM_FUNCTION_SELECT || x == `MMT_IDX_OW || x == `MMT_IDX_RUN
			|| x == `MMT_IDX_ONE_SHOT_START_FLAGS || x == `MMT_IDX_TRG || x == `MMT_IDX_UDF
			|| (x >= `MMT_IDX_CNT && x <= `MMT_IDX_CNT + 10'h004)
			|| (x >= `MMT_IDX_MODE && x <= `MMT_IDX_MODE + 10'h004)
			|| (x >= `MMT_IDX_RL2 && x <= `MMT_IDX_RL2 + 10'h004);
	endfunction

	function automatic logic dtick(input logic [7:0] v, input logic [3:0] n);
		logic [8:0] m;
		m = (9'h001 << n) - 9'h001;
		return &(v | ~m[7:0]);
	endfunction

	function automatic logic pick_tick(input logic [3:0] s, input logic [1:0] k,
			input logic [3:0] t);
		logic [1:0] c;
		c = s[3] ? (s[2] ? 2'd0 : s[1:0]) : k;
		return t[c];
	endfunction

	assign ar_idx = s_axi_araddr[11:2];
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_ok = idx_ok(aw_idx_r);
	assign src_all = {src_r[2], src_r[1], src_r[0]};
	assign tsel_all = {trg_r, one_shot_start_flags_r[7:6]};

	// Count-source ticks derived from one free divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dv_r <= `MMT_RST_BYTE;
		end else begin
			dv_r <= dv_r + 8'h01;
		end
	end
	always_comb begin
		base_sh = pdiv_r[`MMT_BIT_PDIV] ? `MMT_SH_PDIV : 4'd0;
		tks[0] = dtick(dv_r, base_sh + {3'd0, !pclk_r[0]});
		tks[1] = dtick(dv_r, base_sh + `MMT_SH_D8);
		tks[2] = dtick(dv_r, base_sh + `MMT_SH_D32);
		tks[3] = dtick(dv_r, base_sh + `MMT_SH_D64);
	end

	// AXI4-Lite address, data and response handshakes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MMT_RESP_OK;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_idx_r <= 10'h000;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[11:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `MMT_RESP_OK : `MMT_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = idx_ok(ar_idx);
		for (int i = 0; i < 5; i++) begin
			if (ar_idx == `MMT_IDX_CNT + 10'(i)) rd_data[15:0] = cnt_q[i];
			if (ar_idx == `MMT_IDX_RL2 + 10'(i)) rd_data[15:0] = rl2_q[i];
			if (ar_idx == `MMT_IDX_MODE + 10'(i)) rd_data[7:0] = mode_r[i];
		end
		for (int i = 0; i < 3; i++) begin
			if (ar_idx == `MMT_IDX_SRC0 + 10'(i)) rd_data[7:0] = src_r[i];
		end
		unique case (ar_idx)
			`MMT_IDX_PCLK: rd_data[7:0] = pclk_r;
			`MMT_IDX_PDIV: rd_data[7:0] = pdiv_r;
			`MMT_IDX_PWM_FUNCTION_SELECT: rd_data[7:0] = pwm_function_select_r;
			`MMT_IDX_POL: rd_data[7:0] = pol_r;
			`MMT_IDX_OW: rd_data[7:0] = ow_r;
			`MMT_IDX_RUN: rd_data[7:0] = run_r;
			`MMT_IDX_ONE_SHOT_START_FLAGS: rd_data[7:0] = one_shot_start_flags_r;
			`MMT_IDX_TRG: rd_data[7:0] = trg_r;
			`MMT_IDX_UDF: rd_data[7:0] = udf_r;
			default: rd_data = rd_data;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `MMT_RESP_OK;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_ok ? `MMT_RESP_OK : `MMT_RESP_ERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Byte-wide control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pclk_r <= {7'h00, `MMT_RST_PCLK};
			{pdiv_r, pwm_function_select_r, pol_r, ow_r} <= {4{`MMT_RST_BYTE}};
			{run_r, one_shot_start_flags_r, trg_r, udf_r} <= {4{`MMT_RST_BYTE}};
			src_r <= '{default: `MMT_RST_BYTE};
			mode_r <= '{default: `MMT_RST_BYTE};
			go_r <= 5'h00;
		end else begin
			go_r <= 5'h00;
			if (wr_go && ws_r[0]) begin
				unique case (aw_idx_r)
					`MMT_IDX_PCLK: pclk_r <= wd_r[7:0] & `MMT_MSK_PCLK;
					`MMT_IDX_PDIV: pdiv_r <= wd_r[7:0] & `MMT_MSK_PDIV;
					`MMT_IDX_PWM_FUNCTION_SELECT: pwm_function_select_r <= wd_r[7:0] & `MMT_MSK_PO;
					`MMT_IDX_POL: pol_r <= wd_r[7:0] & `MMT_MSK_POL;
					`MMT_IDX_OW: ow_r <= wd_r[7:0] & `MMT_MSK_PO;
					`MMT_IDX_RUN: run_r <= wd_r[7:0] & `MMT_MSK_RUN;
					`MMT_IDX_ONE_SHOT_START_FLAGS: begin
						one_shot_start_flags_r <= wd_r[7:0] & `MMT_MSK_ONE_SHOT_START_FLAGS;
						go_r <= wd_r[4:0];
					end
					`MMT_IDX_TRG: trg_r <= wd_r[7:0];
					`MMT_IDX_UDF: udf_r <= wd_r[7:0];
					default: ;
				endcase
				for (int i = 0; i < 5; i++) begin
					if (aw_idx_r == `MMT_IDX_MODE + 10'(i)) mode_r[i] <= wd_r[7:0];
				end
				for (int i = 0; i < 3; i++) begin
					if (aw_idx_r == `MMT_IDX_SRC0 + 10'(i)) src_r[i] <= wd_r[7:0];
				end
			end
		end
	end

	// One counter channel per generate entry
	for (genvar g = 0; g < 5; g++) begin : g_ch
		localparam bit CAN_PO = (g == 1) || (g == 2) || (g == 4);
		localparam bit CAN_QD = (g >= 2);
		localparam int PRV = (g + 4) % 5;
		localparam int NXT = (g + 1) % 5;
		logic [15:0] cnt_r, rld_r, rl2_r, hi_r, lo_r, ph_r, wdat, rdat;
		logic [7:0] pre_r;
		logic raw_r, in_d_r, z_d_r, irq_r, pin_r, seen_r, trig_ev;
		mmt_st_e st_r;
		mmt_mode_e md;
		logic [7:0] mr;
		logic tk, pin_edge, qd, po, start, ev, up, zinit, zero_idle, run, wr_c, wr_2;
		logic [1:0] tsel;

		assign mr = mode_r[g];
		assign md = mmt_mode_e'(mr[1:0]);
		assign run = run_r[g];
		assign tk = pick_tick(src_all[4 * g + 3 -: 4], mr[7:6], tks);
		assign tsel = tsel_all[2 * g + 1 -: 2];
		assign pin_edge = mr[`MMT_MR_EDGE] ? (channel_input_pin[g] && !in_d_r)
			: (!channel_input_pin[g] && in_d_r);
		assign qd = CAN_QD && udf_r[`MMT_BIT_QD + g];
		assign po = CAN_PO && md == MMT_PWM && !mr[`MMT_MR_W8] && pwm_function_select_r[g];
		assign start = mr[`MMT_MR_TRG] ? trig_ev : (md == MMT_ONESHOT ? go_r[g] : 1'b1);
		assign ev = (mr[`MMT_MR_TRG] && !qd) ? trig_ev : pin_edge;
		assign up = qd ? 1'b1 : udf_r[g];
		assign zinit = (g == 3) && qd && one_shot_start_flags_r[`MMT_BIT_ZPH] && zphase_pin && !z_d_r;
		assign zero_idle = md == MMT_PWM && !po
			&& (mr[`MMT_MR_W8] ? rld_r[15:8] == 8'h00 : rld_r == 16'h0000);
		assign wr_c = wr_go && aw_idx_r == `MMT_IDX_CNT + 10'(g);
		assign wr_2 = wr_go && aw_idx_r == `MMT_IDX_RL2 + 10'(g);
		assign rdat = wr_2 ? rl2_r : rld_r;
		assign wdat = {ws_r[1] ? wd_r[15:8] : rdat[15:8], ws_r[0] ? wd_r[7:0] : rdat[7:0]};
		assign cnt_q[g] = cnt_r;
		assign rld_q[g] = rld_r;
		assign rl2_q[g] = rl2_r;
		assign irq_q[g] = irq_r;

		always_comb begin
			unique case (tsel)
				2'b00: trig_ev = pin_edge;
				2'b01: trig_ev = ext_event_in;
				2'b10: trig_ev = irq_q[PRV];
				2'b11: trig_ev = irq_q[NXT];
			endcase
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				{cnt_r, rld_r, rl2_r, hi_r, lo_r, ph_r} <= {6{`MMT_RST_WORD}};
				pre_r <= `MMT_RST_BYTE;
				{raw_r, in_d_r, z_d_r, irq_r, pin_r, seen_r} <= 6'h00;
				st_r <= MMT_IDLE;
			end else begin
				in_d_r <= channel_input_pin[g];
				z_d_r <= zphase_pin;
				irq_r <= 1'b0;
				pin_r <= zero_idle ? 1'b0 : raw_r ^ pol_r[g];
				if (!run) begin
					st_r <= MMT_IDLE;
					raw_r <= 1'b0;
					seen_r <= 1'b0;
				end else begin
					if (tk) seen_r <= 1'b1;
					unique case (md)
						MMT_TIMER: if (tk) begin
							cnt_r <= cnt_r - 16'h0001;
							if (cnt_r == 16'h0000) begin
								cnt_r <= rld_r;
								irq_r <= 1'b1;
								raw_r <= mr[`MMT_MR_OUT] && !raw_r;
							end
						end
						MMT_EVENT: if (zinit) begin
							cnt_r <= rld_r;
						end else if (ev) begin
							cnt_r <= up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
							if (cnt_r == (up ? 16'hffff : 16'h0000)) begin
								cnt_r <= rld_r;
								irq_r <= 1'b1;
								raw_r <= mr[`MMT_MR_OUT] && !raw_r;
							end
						end
						MMT_ONESHOT: if (st_r == MMT_IDLE) begin
							if (start && rld_r != 16'h0000) begin
								st_r <= MMT_HI;
								cnt_r <= rld_r;
								raw_r <= mr[`MMT_MR_OUT];
							end
						end else if (tk) begin
							cnt_r <= cnt_r - 16'h0001;
							if (cnt_r <= 16'h0001) begin
								st_r <= MMT_IDLE;
								raw_r <= 1'b0;
								irq_r <= 1'b1;
							end
						end
						MMT_PWM: if (po) begin
							if (st_r == MMT_IDLE) begin
								if (start) begin
									st_r <= MMT_HI;
									hi_r <= rld_r;
									lo_r <= rl2_r;
									cnt_r <= rld_r;
									raw_r <= 1'b1;
								end
							end else if (tk) begin
								cnt_r <= cnt_r - 16'h0001;
								if (cnt_r <= 16'h0001 && st_r == MMT_HI) begin
									st_r <= MMT_LO;
									cnt_r <= lo_r;
									raw_r <= 1'b0;
								end else if (cnt_r <= 16'h0001) begin
									st_r <= MMT_HI;
									raw_r <= 1'b1;
									irq_r <= 1'b1;
									cnt_r <= hi_r;
									if (ow_r[g]) begin
										hi_r <= rld_r;
										lo_r <= rl2_r;
										cnt_r <= rld_r;
									end
								end
							end
						end else if (zero_idle) begin
							st_r <= MMT_IDLE;
							raw_r <= 1'b0;
						end else if (st_r == MMT_IDLE) begin
							if (start) begin
								st_r <= MMT_HI;
								ph_r <= 16'h0000;
								pre_r <= 8'h00;
							end
						end else if (tk && !mr[`MMT_MR_W8]) begin
							ph_r <= (ph_r == `MMT_PWM16_END) ? 16'h0000 : ph_r + 16'h0001;
							raw_r <= ph_r < rld_r;
							irq_r <= ph_r == rld_r;
						end else if (tk) begin
							pre_r <= (pre_r == rld_r[7:0]) ? 8'h00 : pre_r + 8'h01;
							if (pre_r == rld_r[7:0]) begin
								ph_r[7:0] <= (ph_r[7:0] == `MMT_PWM8_END) ? 8'h00
									: ph_r[7:0] + 8'h01;
								raw_r <= ph_r[7:0] < rld_r[15:8];
								irq_r <= ph_r[7:0] == rld_r[15:8];
							end
						end
					endcase
				end
				if (wr_c) begin
					rld_r <= wdat;
					if (!run || !seen_r) cnt_r <= wdat;
				end
				if (wr_2) rl2_r <= wdat;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				channel_output_pin[g] <= 1'b0;
				timer_request[g] <= 1'b0;
			end else begin
				channel_output_pin[g] <= pin_r;
				timer_request[g] <= irq_r;
			end
		end
	end
endmodule
`default_nettype wire

// *** multi_mode_timer_config_tb.sv ***
// Register and pin checks for the timer bank
`timescale 1ns/1ps
`default_nettype none
`include "mmt_regs.svh"
`define MMT_CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module multi_mode_timer_config_tb;
	logic aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [4:0] channel_input_pin, channel_output_pin, timer_request, req_seen;
	logic zphase_pin, ext_event_in;
	int n_fail = 0, cmp_count = 0;
	int hi_run = 0, hi_len = 0;
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) req_seen <= clr ? 5'h00 : (req_seen | timer_request);
	// Length of the last high pulse on channel 1
	always @(posedge aclk) begin
		if (channel_output_pin[1] === 1'b1) begin
			hi_run <= hi_run + 1;
		end else begin
			if (hi_run != 0) hi_len <= hi_run;
			hi_run <= 0;
		end
	end
	mmt_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .channel_input_pin(channel_input_pin), .zphase_pin(zphase_pin),
		.ext_event_in(ext_event_in), .channel_output_pin(channel_output_pin),
		.timer_request(timer_request));
	mmt_pin_model u_pins (.aclk(aclk), .aresetn(aresetn), .channel_input_pin(channel_input_pin),
		.zphase_pin(zphase_pin), .ext_event_in(ext_event_in));
	task automatic end_of_test();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [15:0] d,
		input logic [1:0] er = `MMT_RESP_OK, input int lag = 0);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_bready <= (lag == 0);
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				a = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		repeat (lag) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		`MMT_CHK("bresp", er, s_axi_bresp)
	endtask
	task automatic rd(input logic [9:0] idx, input logic [15:0] e,
		input logic [1:0] er = `MMT_RESP_OK, input int lag = 0);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		repeat (lag) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		`MMT_CHK("rdata", {16'h0000, e}, s_axi_rdata)
		`MMT_CHK("rresp", er, s_axi_rresp)
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		end_of_test();
	end
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`MMT_IDX_PCLK, 16'h0001);
		rd(`MMT_IDX_POL, 16'h0000);
		rd(`MMT_IDX_RUN, 16'h0000);
		wr(`MMT_IDX_PDIV, 16'h0000);
		wr(`MMT_IDX_PWM_FUNCTION_SELECT, 16'h00ff);
		rd(`MMT_IDX_PWM_FUNCTION_SELECT, 16'h0016);
		wr(`MMT_IDX_ONE_SHOT_START_FLAGS, 16'h00ff);
		rd(`MMT_IDX_ONE_SHOT_START_FLAGS, 16'h00e0);
		wr(10'h3ff, 16'h00ff, `MMT_RESP_ERR);
		rd(10'h3ff, 16'h0000, `MMT_RESP_ERR);
		wr(`MMT_IDX_ONE_SHOT_START_FLAGS, 16'h0000);
		wr(`MMT_IDX_PWM_FUNCTION_SELECT, 16'h0000);
		wr(`MMT_IDX_UDF, 16'h0000);
		wr(`MMT_IDX_POL, 16'h0002, `MMT_RESP_OK, 2);
		rd(`MMT_IDX_POL, 16'h0002, `MMT_RESP_OK, 3);
		wr(`MMT_IDX_MODE + 10'h001, 16'h0007);
		wr(`MMT_IDX_CNT + 10'h001, 16'h0000);
		wr(`MMT_IDX_MODE, 16'h0006);
		wr(`MMT_IDX_CNT, 16'h0000);
		wr(`MMT_IDX_CNT + 10'h002, 16'h1234);
		rd(`MMT_IDX_CNT + 10'h002, 16'h1234);
		wr(`MMT_IDX_MODE + 10'h003, 16'h0000);
		wr(`MMT_IDX_CNT + 10'h003, 16'h0003);
		wr(`MMT_IDX_MODE + 10'h004, 16'h0009);
		wr(`MMT_IDX_CNT + 10'h004, 16'h0002);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		wr(`MMT_IDX_RUN, 16'h001b);
		wr(`MMT_IDX_ONE_SHOT_START_FLAGS, 16'h0001);
		repeat (200) @(posedge aclk);
		`MMT_CHK("req ch0", 1'b0, req_seen[0])
		`MMT_CHK("out ch0", 1'b0, channel_output_pin[0])
		`MMT_CHK("req ch1", 1'b0, req_seen[1])
		`MMT_CHK("out ch1", 1'b0, channel_output_pin[1])
		`MMT_CHK("req ch3", 1'b1, req_seen[3])
		`MMT_CHK("req ch4", 1'b1, req_seen[4])
		wr(`MMT_IDX_RUN, 16'h0000);
		wr(`MMT_IDX_POL, 16'h0000);
		wr(`MMT_IDX_MODE + 10'h001, 16'h0003);
		wr(`MMT_IDX_PWM_FUNCTION_SELECT, 16'h0002);
		wr(`MMT_IDX_CNT + 10'h001, 16'h0003);
		wr(`MMT_IDX_RL2 + 10'h001, 16'h0002);
		wr(`MMT_IDX_RUN, 16'h0002);
		repeat (40) @(posedge aclk);
		`MMT_CHK("po high ch1", 3, hi_len)
		wr(`MMT_IDX_OW, 16'h0000);
		wr(`MMT_IDX_CNT + 10'h001, 16'h0005);
		repeat (40) @(posedge aclk);
		`MMT_CHK("po keep ch1", 3, hi_len)
		wr(`MMT_IDX_OW, 16'h0002);
		repeat (40) @(posedge aclk);
		`MMT_CHK("po update ch1", 5, hi_len)
		end_of_test();
	end
endmodule
bind mmt_top mmt_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
